/* File: hdl/pse_link_if.sv */
// Command-byte link between the telemetry host and the device.
// Assumes both ends share clk; every strobe lasts one cycle.
`timescale 1ns/1ns
`default_nettype none
interface pse_link_if;
    logic req; // Host: start a command, one cycle
    logic [7:0] req_cmd; // Host: command code
    logic req_write; // Host: command is a write
    logic [7:0] req_wdata; // Host: write data byte
    logic next; // Host: ask for the second byte
    logic ack; // Device: byte ready, one cycle
    logic [7:0] rdata; // Device: returned byte
    modport dev (input req, req_cmd, req_write, req_wdata, next,
        output ack, rdata);
    modport host (output req, req_cmd, req_write, req_wdata, next,
        input ack, rdata);
endinterface : pse_link_if
`default_nettype wire

/* File: hdl/pse_port_current_hold.sv */
// Holds one port's current code between conversions.
// Assumes converter strobes are single-cycle pulses on clk.
`timescale 1ns/1ns
`default_nettype none
module pse_port_current_hold (
    input wire logic clk,
    input wire logic nrst,
    input wire logic meas_done,
    input wire pse_telemetry_pkg::code_t meas_code,
    input wire logic class_done,
    input wire pse_telemetry_pkg::code_t class_code,
    input wire logic port_off,
    output pse_telemetry_pkg::code_t code,
    output logic class_shown
);
    import pse_telemetry_pkg::*;
    code_t next_code; // Next held code
    logic next_class_shown; // Next class flag

    // Disable clears; powered reading beats a class reading
    always_comb begin
        next_code = code;
        next_class_shown = class_shown;
        if (port_off) begin
            next_code = '0;
            next_class_shown = 1'b0;
        end else if (meas_done) begin
            next_code = meas_code;
            next_class_shown = 1'b0;
        end else if (class_done) begin
            next_code = class_code;
            next_class_shown = 1'b1;
        end
    end

    // Register state; cleared at reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            code <= '0;
            class_shown <= 1'b0;
        end else begin
            code <= next_code;
            class_shown <= next_class_shown;
        end
    end
endmodule : pse_port_current_hold
`default_nettype wire

/* File: hdl/pse_telemetry_dev.sv */
// Device end of the telemetry readout: read-only result registers
// answering command bytes over the link.
// Assumes converter codes and strobes come from logic on clk.
// Results are raw codes; scaling to units is left to software.
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
module pse_telemetry_dev #(
    parameter int TEMP_PERIOD = pse_telemetry_pkg::TEMP_PERIOD_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    pse_link_if.dev link,
    input wire logic [pse_telemetry_pkg::TEMP_W-1:0] die_temp_code,
    input wire logic supply_volt_done,
    input wire pse_telemetry_pkg::code_t supply_volt_code,
    input wire logic [pse_telemetry_pkg::NPORTS-1:0] port_meas_done,
    input wire pse_telemetry_pkg::code_t
        [pse_telemetry_pkg::NPORTS-1:0] port_meas_code,
    input wire logic [pse_telemetry_pkg::NPORTS-1:0] port_class_done,
    input wire pse_telemetry_pkg::code_t
        [pse_telemetry_pkg::NPORTS-1:0] port_class_code,
    input wire logic [pse_telemetry_pkg::NPORTS-1:0] port_off,
    output logic temp_sampled,
    output logic [pse_telemetry_pkg::NPORTS-1:0] port_class_shown
);
    import pse_telemetry_pkg::*;

    // Refresh interval as a counter terminal value
    // Timer counts from zero, so the last count is one short
    localparam logic [TIMER_W-1:0] TIMER_LAST =
        TIMER_W'(TEMP_PERIOD - 1);

    // Result registers
    // All hold raw converter codes, cleared at reset
    logic [TEMP_W-1:0] die_temp; // Held temperature code
    logic [TEMP_W-1:0] next_die_temp; // Next temperature code
    code_t supply_volt; // Held supply voltage code
    code_t next_supply_volt; // Next supply voltage code
    code_t [NPORTS-1:0] port_current_code; // Held port currents

    // Refresh timer
    logic [TIMER_W-1:0] timer; // Cycles since last refresh
    logic [TIMER_W-1:0] next_timer; // Next timer value
    logic next_temp_sampled; // Refresh strobe next cycle

    // Link answer state
    dev_state_t state; // Whether a second byte is owed
    dev_state_t next_state; // Next link state
    logic [15:0] shadow; // Snapshot of the selected result
    logic [15:0] next_shadow; // Next snapshot
    logic [15:0] sel_value; // Current value of the addressed result
    logic ack; // Registered answer strobe
    logic next_ack; // Next answer strobe
    logic [7:0] rdata; // Registered answer byte
    logic [7:0] next_rdata; // Next answer byte

    // Per-port current holders
    // Entry 0 holds port 1, entry 2 holds port 3
    // Each holder arbitrates disable, powered and class readings
    genvar p;
    generate
        for (p = 0; p < NPORTS; p++) begin : g_port
            // One holder per port; class codes keep their finer scale
            pse_port_current_hold u_hold (
                .clk(clk),
                .nrst(nrst),
                .meas_done(port_meas_done[p]),
                .meas_code(port_meas_code[p]),
                .class_done(port_class_done[p]),
                .class_code(port_class_code[p]),
                .port_off(port_off[p]),
                .code(port_current_code[p]),
                .class_shown(port_class_shown[p])
            );
        end
    endgenerate

    // Autonomous temperature refresh, no host involvement
    // Same-domain input, so no synchroniser is needed
    // Capture and strobe share an edge; the strobe shows with the new value
    always_comb begin
        next_timer = timer + TIMER_W'(1);
        next_temp_sampled = 1'b0;
        next_die_temp = die_temp;
        if (timer == TIMER_LAST) begin
            next_timer = '0;
            next_temp_sampled = 1'b1;
            next_die_temp = die_temp_code;
        end
    end

    // Register the refresh group
    // First capture comes one full period after reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            timer <= '0;
            temp_sampled <= 1'b0;
            die_temp <= '0;
        end else begin
            timer <= next_timer;
            temp_sampled <= next_temp_sampled;
            die_temp <= next_die_temp;
        end
    end

    // Supply voltage follows each finished conversion
    // No timer here: the converter sets the update pace
    always_comb begin
        next_supply_volt = supply_volt;
        if (supply_volt_done) begin
            next_supply_volt = supply_volt_code;
        end
    end

    // Register the supply voltage
    // Reads zero until the first conversion lands
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            supply_volt <= '0;
        end else begin
            supply_volt <= next_supply_volt;
        end
    end

    // Select the result named by the command, upper bits zero
    // Only looked at while req is high, so glitches do no harm
    // Unmapped codes read zero and owe no second byte
    always_comb begin
        case (link.req_cmd)
            CMD_TEMP: sel_value = {8'h00, die_temp};
            CMD_VOLT: sel_value = {2'h0, supply_volt};
            CMD_PORT1: sel_value = {2'h0, port_current_code[0]};
            CMD_PORT2: sel_value = {2'h0, port_current_code[1]};
            CMD_PORT3: sel_value = {2'h0, port_current_code[2]};
            default: sel_value = 16'h0000; // Unmapped reads zero
        endcase
    end

    // Answer commands; a second byte comes from the snapshot
    // The snapshot taken on req keeps both bytes from one value,
    // so a conversion landing between them cannot tear the result.
    // Every req is acked, even unmapped or write, so no host hangs.
    always_comb begin
        next_state = state;
        next_shadow = shadow;
        next_ack = 1'b0;
        next_rdata = rdata;
        if (link.req) begin
            // A new command always restarts the exchange
            next_ack = 1'b1;
            next_state = D_IDLE;
            if (link.req_write) begin
                // Read-only group: write data is dropped
                next_rdata = 8'h00;
            end else begin
                next_shadow = sel_value;
                next_rdata = sel_value[7:0];
                if (cmd_bytes(link.req_cmd) == 2'h2) begin
                    next_state = D_HAVE_HI;
                end
            end
        end else if (link.next) begin
            case (state)
                D_HAVE_HI: begin
                    // High byte of the same snapshot
                    next_ack = 1'b1;
                    next_rdata = shadow[15:8];
                    next_state = D_IDLE;
                end
                default: begin
                    // Stray next with nothing owed is ignored
                    next_state = D_IDLE;
                end
            endcase
        end
    end

    // Register the link answer group
    // Reset leaves rdata at zero so the link idles quietly
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= D_IDLE;
            shadow <= 16'h0000;
            ack <= 1'b0;
            rdata <= 8'h00;
        end else begin
            state <= next_state;
            shadow <= next_shadow;
            ack <= next_ack;
            rdata <= next_rdata;
        end
    end

    // Drive the link from flops
    // Flops only, so the host samples settled values at each edge
    assign link.ack = ack;
    assign link.rdata = rdata;
endmodule : pse_telemetry_dev
`default_nettype wire

/* File: hdl/pse_telemetry_host.sv */
// Host end: takes orders over Avalon-MM and runs link exchanges.
// Assumes the device acks each req or next within a few cycles.
`timescale 1ns/1ns
`default_nettype none
module pse_telemetry_host (
    input wire logic clk,
    input wire logic nrst,
    pse_link_if.host link,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest
);
    import pse_telemetry_pkg::*;
    host_state_t state; // Exchange state
    host_state_t next_state; // Next exchange state
    logic [7:0] cmd; // Command being run
    logic [7:0] next_cmd; // Next command
    logic [7:0] wdata; // Write byte being sent
    logic [7:0] next_wdata; // Next write byte
    logic wr; // Exchange is a write
    logic next_wr; // Next write flag
    logic [15:0] result; // Bytes gathered, low first
    logic [15:0] next_result; // Next result
    logic done; // Last exchange finished
    logic next_done; // Next done flag
    logic acc; // Bus access answered this cycle
    logic next_acc; // Next access flag
    logic [31:0] next_readdata; // Next read data
    logic busy; // Exchange in progress
    logic stall; // Control write must wait
    logic start; // Control write accepted now

    assign busy = (state != H_IDLE);
    assign stall = write && (address == HREG_CTRL) && busy;
    assign start = write && acc && (address == HREG_CTRL);
    assign waitrequest = (read || write) && !acc;
    assign link.req = (state == H_REQ);
    assign link.next = (state == H_NEXT);
    assign link.req_cmd = cmd;
    assign link.req_write = wr;
    assign link.req_wdata = wdata;

    // One wait state per access, more while a start must wait
    always_comb begin
        next_acc = (read || write) && !acc && !stall;
        next_readdata = readdata;
        if (next_acc && read) begin
            case (address)
                HREG_CTRL: next_readdata = {15'h0000, wr, wdata, cmd};
                HREG_STATUS: next_readdata = {30'h00000000, done, busy};
                HREG_RESULT: next_readdata = {16'h0000, result};
                default: next_readdata = 32'h00000000;
            endcase
        end
    end

    // Exchange sequencer
    always_comb begin
        next_state = state;
        next_cmd = cmd;
        next_wdata = wdata;
        next_wr = wr;
        next_result = result;
        next_done = done;
        case (state)
            H_IDLE: begin
                if (start) begin
                    next_cmd = writedata[7:0];
                    next_wdata = writedata[CTRL_WDATA_LSB +: 8];
                    next_wr = writedata[CTRL_WRITE_BIT];
                    next_result = 16'h0000;
                    next_done = 1'b0;
                    next_state = H_REQ;
                end
            end
            H_REQ: next_state = H_LO;
            H_LO: begin
                if (link.ack) begin
                    next_result[7:0] = link.rdata;
                    if (!wr && cmd_bytes(cmd) == 2'h2) begin
                        next_state = H_NEXT;
                    end else begin
                        next_done = 1'b1;
                        next_state = H_IDLE;
                    end
                end
            end
            H_NEXT: next_state = H_HI;
            H_HI: begin
                if (link.ack) begin
                    next_result[15:8] = link.rdata;
                    next_done = 1'b1;
                    next_state = H_IDLE;
                end
            end
            default: next_state = H_IDLE;
        endcase
    end

    // Register host state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= H_IDLE;
            cmd <= 8'h00;
            wdata <= 8'h00;
            wr <= 1'b0;
            result <= 16'h0000;
            done <= 1'b0;
            acc <= 1'b0;
            readdata <= 32'h00000000;
        end else begin
            state <= next_state;
            cmd <= next_cmd;
            wdata <= next_wdata;
            wr <= next_wr;
            result <= next_result;
            done <= next_done;
            acc <= next_acc;
            readdata <= next_readdata;
        end
    end
endmodule : pse_telemetry_host
`default_nettype wire

/* File: hdl/pse_telemetry_pkg.sv */
// Shared constants for the telemetry readout link and both of its ends.
// Assumes a single 250 MHz system clock on both ends.
package pse_telemetry_pkg;
    // Clock period and autonomous temperature refresh period
    localparam int CLK_PERIOD_NS = 4;
    localparam int TEMP_PERIOD_MS = 1000;
    localparam int TEMP_PERIOD_CYC = TEMP_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TIMER_W = 28;
    // Command codes of the read-only group
    localparam logic [7:0] CMD_TEMP = 8'h2C;
    localparam logic [7:0] CMD_VOLT = 8'h2E;
    localparam logic [7:0] CMD_PORT1 = 8'h30;
    localparam logic [7:0] CMD_PORT2 = 8'h34;
    localparam logic [7:0] CMD_PORT3 = 8'h38;
    // Field widths and port count
    localparam int TEMP_W = 8;
    localparam int CODE_W = 14;
    localparam int NPORTS = 3;
    // Conversion scales, informational for software
    localparam real TEMP_OFFSET_C = -20.0;
    localparam real TEMP_STEP_C = 0.652;
    localparam real TEMP_FULL_C = 146.2;
    localparam real VOLT_STEP_MV = 3.662;
    localparam real VOLT_FULL_V = 60.0;
    localparam real CUR_FULL_A = 1.46;
    localparam real CLASS_STEP_UA = 8.95;
    localparam int CLASS_SCALE_DIV = 10;
    // Host-side register byte addresses and fields
    localparam logic [3:0] HREG_CTRL = 4'h0;
    localparam logic [3:0] HREG_STATUS = 4'h4;
    localparam logic [3:0] HREG_RESULT = 4'h8;
    localparam int CTRL_WDATA_LSB = 8;
    localparam int CTRL_WRITE_BIT = 16;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    typedef logic [CODE_W-1:0] code_t;
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_REQ = 3'b001,
        H_LO = 3'b010,
        H_NEXT = 3'b011,
        H_HI = 3'b100
    } host_state_t;
    typedef enum logic [0:0] {
        D_IDLE = 1'b0,
        D_HAVE_HI = 1'b1
    } dev_state_t;
    // Data bytes a command returns; zero for unmapped codes
    function automatic logic [1:0] cmd_bytes(input logic [7:0] cmd);
        case (cmd)
            CMD_TEMP: cmd_bytes = 2'h1;
            CMD_VOLT, CMD_PORT1, CMD_PORT2, CMD_PORT3: cmd_bytes = 2'h2;
            default: cmd_bytes = 2'h0;
        endcase
    endfunction : cmd_bytes
endpackage : pse_telemetry_pkg

/* File: verification/pse_telemetry_checker.sv */
// Concurrent checks on the link between host and device ends.
// Assumes one clk and an active-low async nrst on both ends.
`timescale 1ns/1ns
`default_nettype none
module pse_telemetry_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic req,
    input wire logic [7:0] req_cmd,
    input wire logic req_write,
    input wire logic next,
    input wire logic ack,
    input wire logic [7:0] rdata
);
    import pse_telemetry_pkg::*;
    // All checks on clk, idle in reset
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // Every command is answered one cycle later
    ack_after_req_a: assert property (req |=> ack)
        else $error("no ack after req");
    // Ack is a single-cycle pulse
    ack_pulse_a: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    // Ack only answers a req or next
    ack_cause_a: assert property (ack |-> $past(req) || $past(next))
        else $error("ack without cause");
    // Write commands return a zero byte
    write_zero_a: assert property (req && req_write |=> rdata == 8'h00)
        else $error("write returned data");
    // Temperature is a single byte
    temp_single_a: assert property (req && !req_write && req_cmd == CMD_TEMP
        |=> ack ##1 !ack [*2])
        else $error("temperature sent extra byte");
    // Two-byte reads: low, next, high byte
    two_byte_a: assert property (req && !req_write && cmd_bytes(req_cmd) == 2
        |=> ack ##1 next ##1 (ack && rdata[7:6] == 2'b00))
        else $error("two-byte read sequence broken");
    // High byte top bits always zero
    hi_byte_a: assert property (next |=> ack && rdata[7:6] == 2'b00)
        else $error("high byte upper bits set");
    // Returned byte stands between acks
    rdata_hold_a: assert property (!ack |-> $stable(rdata))
        else $error("rdata changed without ack");
    // Next only right after an ack
    next_after_ack_a: assert property (next |-> $past(ack))
        else $error("next without prior ack");
    // Commands are spaced apart
    req_gap_a: assert property (req |=> !req [*2])
        else $error("req too close");
endmodule : pse_telemetry_checker
`default_nettype wire

/* File: verification/pse_telemetry_readout_regs_tb.sv */
// Self-checking bench: host and device ends joined by the link.
// Assumes the design package and interface are compiled first.
`timescale 1ns/1ns
`default_nettype none
module pse_telemetry_readout_regs_tb;
    import pse_telemetry_pkg::*;
    localparam int TP = 16; // Short temperature period
    localparam logic [7:0] CMDS [5] = '{CMD_TEMP, CMD_VOLT, CMD_PORT1,
        CMD_PORT2, CMD_PORT3}; // Read group in order
    logic clk, nrst; // Clock and active-low reset
    logic [3:0] address; // Avalon address
    logic read, write, waitrequest; // Avalon controls
    logic [31:0] writedata, readdata, rv; // Avalon data, last read
    logic [7:0] tcode, t; // Temperature input, expected
    logic vdone, tsamp; // Voltage strobe, capture pulse
    code_t vcode, cc, m; // Voltage input, class and meas codes
    code_t ex [4]; // Expected voltage and port codes
    logic [NPORTS-1:0] mdone, cdone, poff, cshown; // Port controls
    code_t [NPORTS-1:0] mcode, ccode; // Port code inputs
    logic [32:0] expq [$]; // Notes: check flag and value
    logic [32:0] e; // Oldest note
    int n_mismatch, checks_done, cyc, c0; // Counters
    pse_link_if lnk();
    pse_telemetry_dev #(.TEMP_PERIOD(TP)) pse_telemetry_dev_inst (
        .clk(clk), .nrst(nrst), .link(lnk), .die_temp_code(tcode),
        .supply_volt_done(vdone), .supply_volt_code(vcode),
        .port_meas_done(mdone), .port_meas_code(mcode),
        .port_class_done(cdone), .port_class_code(ccode),
        .port_off(poff), .temp_sampled(tsamp), .port_class_shown(cshown));
    pse_telemetry_host pse_telemetry_host_inst (.clk(clk), .nrst(nrst),
        .link(lnk), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest));
    pse_telemetry_checker pse_telemetry_checker_inst (.clk(clk),
        .nrst(nrst), .req(lnk.req), .req_cmd(lnk.req_cmd),
        .req_write(lnk.req_write), .next(lnk.next), .ack(lnk.ack),
        .rdata(lnk.rdata));
    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Verdict and end of run
    task automatic summarize;
        if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    // One comparison
    task automatic cmp(input logic [31:0] got, input logic [31:0] x);
        checks_done++;
        if (got !== x) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, got, x);
        end
    endtask : cmp
    // Compare each finished read with its oldest note; hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (read && !waitrequest) begin
            e = expq.pop_front();
            if (e[32]) cmp(readdata, e[31:0]);
        end
        if (cyc == 5000) begin
            n_mismatch++;
            summarize();
        end
    end
    // One Avalon access, held until waitrequest is low
    task automatic av(input logic [3:0] a, input logic w,
        input logic [31:0] d);
        @(posedge clk);
        address <= a;
        read <= !w;
        write <= w;
        writedata <= d;
        @(posedge clk iff !waitrequest);
        rv = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : av
    // Start an exchange and poll until done
    task automatic run(input logic [7:0] c, input logic w);
        av(HREG_CTRL, 1'b1, (32'(w) << CTRL_WRITE_BIT) | 32'h5A00 | 32'(c));
        for (int i = 0; i < 20; i++) begin
            expq.push_back(33'h0);
            av(HREG_STATUS, 1'b0, 32'h0);
            if (rv[STAT_DONE_BIT]) break;
        end
    endtask : run
    // Expect a value in RESULT
    task automatic res(input logic [15:0] x);
        expq.push_back({1'b1, 16'h0, x});
        av(HREG_RESULT, 1'b0, 32'h0);
    endtask : res
    // Main sequence
    initial begin
        nrst = 1'b0;
        {address, read, write, writedata, tcode, vdone, vcode} = '0;
        {mdone, mcode, cdone, ccode, poff} = '0;
        {n_mismatch, checks_done, cyc} = '0;
        void'($urandom(32'h8DC8));
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            run(CMDS[i], 1'b0);
            res(16'h0);
        end
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 4; i++) ex[i] = k ? code_t'($urandom) : '1;
            @(posedge clk);
            vcode <= ex[0];
            mcode <= {ex[3], ex[2], ex[1]};
            vdone <= 1'b1;
            mdone <= 3'h7;
            @(posedge clk);
            vdone <= 1'b0;
            mdone <= 3'h0;
            for (int i = 1; i < 5; i++) begin
                run(CMDS[i], 1'b0);
                res({2'b00, ex[i-1]});
            end
        end
        run(CMD_PORT1, 1'b1);
        res(16'h0);
        run(CMD_PORT1, 1'b0);
        res({2'b00, ex[1]});
        run(8'h2D, 1'b0);
        res(16'h0);
        expq.push_back({1'b1, 32'h00005A2D});
        av(HREG_CTRL, 1'b0, 32'h0);
        expq.push_back({1'b1, 32'h1 << STAT_DONE_BIT});
        av(HREG_STATUS, 1'b0, 32'h0);
        expq.push_back(33'h100000000);
        av(4'hC, 1'b0, 32'h0);
        t = 8'($urandom);
        tcode <= t;
        @(posedge clk iff tsamp);
        c0 = cyc;
        @(posedge clk iff tsamp);
        cmp(32'(cyc - c0), 32'(TP));
        run(CMD_TEMP, 1'b0);
        res({8'h00, t});
        cc = code_t'($urandom);
        m = code_t'($urandom);
        ccode[1] <= cc;
        cdone <= 3'h2;
        @(posedge clk);
        cdone <= 3'h0;
        @(posedge clk);
        cmp(32'(cshown), 32'h2);
        fork
            run(CMD_PORT2, 1'b0);
            begin
                repeat (4) @(posedge clk);
                mcode[1] <= m;
                mdone <= 3'h2;
                @(posedge clk);
                mdone <= 3'h0;
            end
        join
        res({2'b00, cc});
        cmp(32'(cshown), 32'h0);
        run(CMD_PORT2, 1'b0);
        res({2'b00, m});
        poff <= 3'h2;
        @(posedge clk);
        poff <= 3'h0;
        run(CMD_PORT2, 1'b0);
        res(16'h0);
        summarize();
    end
endmodule : pse_telemetry_readout_regs_tb
`default_nettype wire
